// ---- common/bldc_drive_pkg.sv ----
// Constants and types shared by the brushless drive control logic.
package bldc_drive_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int CLK_HZ        = 40000000;
  localparam int BLANK_NS      = 700;
  localparam int BLANK_CYC     = (BLANK_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int CHOP_HZ       = 50000;
  localparam int CHOP_CYC      = CLK_HZ / CHOP_HZ;
  localparam int PUMP_HZ       = 100000;
  localparam int PUMP_HALF_CYC = CLK_HZ / PUMP_HZ / 2;
  // Zero duty: input high longer than one period of the slowest PWM.
  localparam int ZERO_US       = 4000;
  localparam int ZERO_CYC      = ZERO_US * (CLK_HZ / 1000000);
  // Lock time: about 90 s per uF; default for 0.022 uF is about 2 s.
  localparam int LOCK_MS       = 2000;
  localparam int LOCK_CYC      = LOCK_MS * (CLK_HZ / 1000);
  localparam int CNT_W         = 32;

  typedef enum logic [2:0] {
    COMM_IDLE, COMM_S1, COMM_S2, COMM_S3, COMM_S4, COMM_S5, COMM_S6
  } comm_t;

  typedef enum {RUN_STOP, RUN_ACTIVE, RUN_LOCKED} run_t;

endpackage : bldc_drive_pkg

// ---- design/bit_sync.sv ----
// Two-stage synchroniser for a group of asynchronous input pins.
`timescale 1ns/10ps
module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] stage1_q;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end

endmodule : bit_sync

// ---- design/bldc_pwm_drive.sv ----
// Brushless motor drive control: PWM, commutation, lock and limiter.
`timescale 1ns/10ps
module bldc_pwm_drive #(
  parameter int LOCK_CYCLES = bldc_drive_pkg::LOCK_CYC,
  parameter int ZERO_CYCLES = bldc_drive_pkg::ZERO_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       pwmDutyInputN,
  input  wire logic       runInput,
  input  wire logic       directionInput,
  input  wire logic [2:0] hallIn,
  input  wire logic       currentAtLimit,
  input  wire logic       thermalShutdown,
  input  wire logic       lowSupply,
  input  wire logic       lockTimerCapGrounded,
  output logic      [2:0] upperOn,
  output logic      [2:0] lowerOn,
  output logic            hallBiasOutput,
  output logic            pumpClock,
  output logic            lockActive,
  output logic            zeroDuty
);

  // -----------------------------------------------------------------------
  // Input synchronisation
  // -----------------------------------------------------------------------
  logic [9:0] rawIn;
  logic [9:0] syncIn;
  logic       pwmOffS;
  logic       runS;
  logic       dirS;
  logic [2:0] hallS;
  logic       limitS;
  logic       hotS;
  logic       lvdS;
  logic       capGndS;

  assign rawIn = {pwmDutyInputN, runInput, directionInput, hallIn,
                  currentAtLimit, thermalShutdown, lowSupply,
                  lockTimerCapGrounded};
  bit_sync #(.W(10)) u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .asyncIn (rawIn),
    .syncOut (syncIn)
  );
  assign {pwmOffS, runS, dirS, hallS, limitS, hotS, lvdS, capGndS} = syncIn;

  // Low supply and a grounded timer pin both hold the logic in reset.
  logic logicRst;
  assign logicRst = !reset_n || lvdS || capGndS;

  // -----------------------------------------------------------------------
  // Zero duty detection
  // -----------------------------------------------------------------------
  logic [bldc_drive_pkg::CNT_W-1:0] zeroCnt_q;
  logic                             zero_q;

  always_ff @(posedge sys_clk) begin
    if (logicRst || !pwmOffS) begin
      zeroCnt_q <= '0;
      zero_q    <= 1'b0;
    end else if (zeroCnt_q >= ZERO_CYCLES[bldc_drive_pkg::CNT_W-1:0] - 1) begin
      zero_q <= 1'b1;
    end else begin
      zeroCnt_q <= zeroCnt_q + 1'b1;
    end
  end
  assign zeroDuty = zero_q;

  // -----------------------------------------------------------------------
  // Hall edge, direction toggle and lock timer
  // -----------------------------------------------------------------------
  logic [2:0]                       hallPrev_q;
  logic                             dirPrev_q;
  logic [bldc_drive_pkg::CNT_W-1:0] lockCnt_q;
  logic                             lock_q;
  logic                             hallEdge;
  logic                             dirEdge;
  logic                             releaseEv;
  assign hallEdge  = hallS != hallPrev_q;
  assign dirEdge   = dirS != dirPrev_q;
  assign releaseEv = !runS || dirEdge || zero_q;

  always_ff @(posedge sys_clk) begin
    if (logicRst) begin
      hallPrev_q <= 3'h0;
      dirPrev_q  <= 1'b0;
    end else begin
      hallPrev_q <= hallS;
      dirPrev_q  <= dirS;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (logicRst || releaseEv) begin
      lockCnt_q <= '0;
      lock_q    <= 1'b0;
    end else if (lock_q || hotS) begin
      lockCnt_q <= lockCnt_q;
    end else if (hallEdge) begin
      lockCnt_q <= '0;
    end else if (lockCnt_q >= LOCK_CYCLES[bldc_drive_pkg::CNT_W-1:0] - 1) begin
      lock_q <= 1'b1;
    end else begin
      lockCnt_q <= lockCnt_q + 1'b1;
    end
  end
  assign lockActive = lock_q;

  // -----------------------------------------------------------------------
  // Current limiter: 50 kHz chop tick, blanking and cycle cut
  // -----------------------------------------------------------------------
  logic [15:0] chopCnt_q;
  logic        chopTick;
  logic [7:0]  blankCnt_q;
  logic        cut_q;
  logic        pwmOnReq;
  logic        upperGate;
  assign chopTick = chopCnt_q == 16'(bldc_drive_pkg::CHOP_CYC - 1);
  assign pwmOnReq = !pwmOffS;

  always_ff @(posedge sys_clk) begin
    if (logicRst || chopTick) begin
      chopCnt_q <= 16'h0;
    end else begin
      chopCnt_q <= chopCnt_q + 16'h1;
    end
  end

  // The sense input is ignored while the upper transistor has just turned
  // on, because diode recovery current would look like an overload.
  always_ff @(posedge sys_clk) begin
    if (logicRst || !upperGate) begin
      blankCnt_q <= 8'h0;
    end else if (blankCnt_q < 8'(bldc_drive_pkg::BLANK_CYC)) begin
      blankCnt_q <= blankCnt_q + 8'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (logicRst) begin
      cut_q <= 1'b0;
    end else if (limitS && upperGate &&
                 blankCnt_q >= 8'(bldc_drive_pkg::BLANK_CYC)) begin
      cut_q <= 1'b1;
    end else if (chopTick) begin
      cut_q <= 1'b0;
    end
  end
  assign upperGate = pwmOnReq && !cut_q && !lock_q;

  // -----------------------------------------------------------------------
  // Commutation
  // -----------------------------------------------------------------------
  function automatic bldc_drive_pkg::comm_t hallToState(
    input logic [2:0] h,
    input logic       rev
  );
    bldc_drive_pkg::comm_t s;
    case (h)
      3'h1:    s = rev ? bldc_drive_pkg::COMM_S4 : bldc_drive_pkg::COMM_S1;
      3'h3:    s = rev ? bldc_drive_pkg::COMM_S5 : bldc_drive_pkg::COMM_S2;
      3'h2:    s = rev ? bldc_drive_pkg::COMM_S6 : bldc_drive_pkg::COMM_S3;
      3'h6:    s = rev ? bldc_drive_pkg::COMM_S1 : bldc_drive_pkg::COMM_S4;
      3'h4:    s = rev ? bldc_drive_pkg::COMM_S2 : bldc_drive_pkg::COMM_S5;
      3'h5:    s = rev ? bldc_drive_pkg::COMM_S3 : bldc_drive_pkg::COMM_S6;
      default: s = bldc_drive_pkg::COMM_IDLE;
    endcase
    return s;
  endfunction : hallToState

  bldc_drive_pkg::comm_t commState;
  logic [2:0]            hiPhase;
  logic [2:0]            loPhase;
  assign commState = hallToState(hallS, dirS);

  always_comb begin
    hiPhase = 3'h0;
    loPhase = 3'h0;
    case (commState)
      bldc_drive_pkg::COMM_S1: begin hiPhase = 3'h1; loPhase = 3'h2; end
      bldc_drive_pkg::COMM_S2: begin hiPhase = 3'h1; loPhase = 3'h4; end
      bldc_drive_pkg::COMM_S3: begin hiPhase = 3'h2; loPhase = 3'h4; end
      bldc_drive_pkg::COMM_S4: begin hiPhase = 3'h2; loPhase = 3'h1; end
      bldc_drive_pkg::COMM_S5: begin hiPhase = 3'h4; loPhase = 3'h1; end
      bldc_drive_pkg::COMM_S6: begin hiPhase = 3'h4; loPhase = 3'h2; end
      default: begin hiPhase = 3'h0; loPhase = 3'h0; end
    endcase
  end

  // -----------------------------------------------------------------------
  // Output stage registers
  // -----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (logicRst) begin
      upperOn <= 3'h0;
      lowerOn <= 3'h0;
    end else if (!runS) begin
      upperOn <= 3'h0;
      lowerOn <= 3'h7;
    end else if (upperGate) begin
      upperOn <= hiPhase;
      lowerOn <= loPhase;
    end else begin
      upperOn <= 3'h0;
      // The upper phase's own low side conducts as synchronous rectifier.
      lowerOn <= loPhase | hiPhase;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (logicRst) begin
      hallBiasOutput <= 1'b0;
    end else begin
      hallBiasOutput <= runS && !zero_q;
    end
  end

  // -----------------------------------------------------------------------
  // Charge pump clock, idle in stop to save power
  // -----------------------------------------------------------------------
  logic [7:0] pumpCnt_q;

  always_ff @(posedge sys_clk) begin
    if (logicRst || !runS) begin
      pumpCnt_q <= 8'h0;
      pumpClock <= 1'b0;
    end else if (pumpCnt_q == 8'(bldc_drive_pkg::PUMP_HALF_CYC - 1)) begin
      pumpCnt_q <= 8'h0;
      pumpClock <= !pumpClock;
    end else begin
      pumpCnt_q <= pumpCnt_q + 8'h1;
    end
  end

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  property p_lock_upper_off;
    @(posedge sys_clk) disable iff (!reset_n)
      lock_q |=> upperOn == 3'h0;
  endproperty
  a_lock_upper_off: assert property (p_lock_upper_off)
    else $error("Upper output on during lock.");

  property p_pwm_high_off;
    @(posedge sys_clk) disable iff (!reset_n)
      pwmOffS |=> upperOn == 3'h0;
  endproperty
  a_pwm_high_off: assert property (p_pwm_high_off)
    else $error("Upper output on while PWM input high.");

  property p_pwm_low_on;
    @(posedge sys_clk) disable iff (logicRst)
      (runS && !pwmOffS && !cut_q && !lock_q && hiPhase != 3'h0)
        |=> upperOn != 3'h0;
  endproperty
  a_pwm_low_on: assert property (p_pwm_low_on)
    else $error("Upper output off while PWM input low.");

  property p_invalid_hall;
    @(posedge sys_clk) disable iff (logicRst)
      (runS && (hallS == 3'h0 || hallS == 3'h7)) |=> upperOn == 3'h0;
  endproperty
  a_invalid_hall: assert property (p_invalid_hall)
    else $error("Output on with invalid Hall code.");

  property p_stop_brake;
    @(posedge sys_clk) disable iff (logicRst)
      !runS |=> lowerOn == 3'h7 && upperOn == 3'h0;
  endproperty
  a_stop_brake: assert property (p_stop_brake)
    else $error("Stop state not in short brake.");

  property p_bias_off;
    @(posedge sys_clk) disable iff (!reset_n)
      (!runS || zero_q) |=> !hallBiasOutput;
  endproperty
  a_bias_off: assert property (p_bias_off)
    else $error("Hall bias on in stop or zero duty.");

  property p_release;
    @(posedge sys_clk) disable iff (!reset_n)
      releaseEv |=> !lock_q && lockCnt_q == '0;
  endproperty
  a_release: assert property (p_release)
    else $error("Lock not released by release event.");

  property p_hot_hold;
    @(posedge sys_clk) disable iff (logicRst)
      (hotS && !releaseEv) |=> $stable(lockCnt_q);
  endproperty
  a_hot_hold: assert property (p_hot_hold)
    else $error("Lock count moved during thermal shutdown.");

  sequence s_blank_start;
    !upperGate ##1 upperGate;
  endsequence

  property p_blanking;
    @(posedge sys_clk) disable iff (logicRst)
      s_blank_start |-> !cut_q [*8];
  endproperty
  a_blanking: assert property (p_blanking)
    else $error("Current cut inside blanking window.");

  property p_cap_reset;
    @(posedge sys_clk) disable iff (!reset_n)
      capGndS |=> upperOn == 3'h0 && !lock_q && !hallBiasOutput;
  endproperty
  a_cap_reset: assert property (p_cap_reset)
    else $error("Logic active with timer pin grounded.");

endmodule : bldc_pwm_drive

// ---- sim/host_pwm.sv ----
// Host controller model that drives the active-low PWM duty pin.
`timescale 1ns/10ps
module host_pwm (
  input  wire logic        sys_clk,
  input  wire logic [1:0]  pwmMode,
  input  wire logic [15:0] periodCyc,
  input  wire logic [15:0] onCyc,
  output logic             pwmDutyInputN
);
  logic [15:0] phase_q;

  // ---------------------------------------------------------------------
  // Pulse generation
  // ---------------------------------------------------------------------
  initial phase_q = 16'h0;

  always @(negedge sys_clk) begin
    phase_q <= (phase_q + 16'h1 >= periodCyc) ? 16'h0 : phase_q + 16'h1;
  end

  // Mode 0 leaves the pin high, 1 holds it low, 2 chops it.
  // The caller keeps the period inside the host's allowed frequency band.
  always_comb begin
    case (pwmMode)
      2'h1:    pwmDutyInputN = 1'b0;
      2'h2:    pwmDutyInputN = (phase_q >= onCyc);
      default: pwmDutyInputN = 1'b1;
    endcase
  end
endmodule : host_pwm

// ---- sim/testbench.sv ----
// Self-checking bench for the brushless drive control logic.
`timescale 1ns/10ps
module testbench;
  localparam int LOCKC = 3000;
  localparam int ZEROC = 1000;
  logic sys_clk, reset_n, pwmDutyInputN, runInput, directionInput;
  logic currentAtLimit, thermalShutdown, lowSupply, lockTimerCapGrounded;
  logic [2:0] hallIn, upperOn, lowerOn;
  logic hallBiasOutput, pumpClock, lockActive, zeroDuty;
  logic [1:0] pwmMode;
  logic [15:0] onCyc;
  int miscompares, nChecks, cyc, n, h, d, p, seed;
  logic [5:0] e;

  // ---------------------------------------------------------------------
  // Clock, design and host model
  // ---------------------------------------------------------------------
  always #12.5 sys_clk = ~sys_clk;

  bldc_pwm_drive #(.LOCK_CYCLES(LOCKC), .ZERO_CYCLES(ZEROC)) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .pwmDutyInputN(pwmDutyInputN),
    .runInput(runInput), .directionInput(directionInput), .hallIn(hallIn),
    .currentAtLimit(currentAtLimit), .thermalShutdown(thermalShutdown),
    .lowSupply(lowSupply), .lockTimerCapGrounded(lockTimerCapGrounded),
    .upperOn(upperOn), .lowerOn(lowerOn), .hallBiasOutput(hallBiasOutput),
    .pumpClock(pumpClock), .lockActive(lockActive), .zeroDuty(zeroDuty));

  host_pwm u_host (.sys_clk(sys_clk), .pwmMode(pwmMode),
    .periodCyc(16'h029b), .onCyc(onCyc), .pwmDutyInputN(pwmDutyInputN));

  // ---------------------------------------------------------------------
  // Reference model and helpers
  // ---------------------------------------------------------------------
  // Returns {upper, lower} for a settled run state.
  function automatic logic [5:0] expOut(int hc, int rv, int on);
    int fu[8] = '{0, 1, 2, 1, 4, 4, 2, 0};
    int fl[8] = '{0, 2, 4, 4, 1, 2, 1, 0};
    int c;
    c = rv ? 7 - hc : hc;
    if (hc == 0 || hc == 7) return 6'h00;
    if (on) return {3'(fu[c]), 3'(fl[c])};
    return {3'h0, 3'(fu[c] | fl[c])};
  endfunction : expOut

  task automatic chk(logic [2:0] got, logic [2:0] exp, string what);
    nChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk

  task automatic wt(int k);
    repeat (k) @(negedge sys_clk);
  endtask : wt

  task automatic close_out();
    if (miscompares == 0 && nChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      close_out();
    end
  end

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0; reset_n = 1'b0; runInput = 1'b1; directionInput = 1'b0;
    hallIn = 3'h1; currentAtLimit = 1'b0; thermalShutdown = 1'b0;
    lowSupply = 1'b0; lockTimerCapGrounded = 1'b0; pwmMode = 2'h1;
    onCyc = 16'h0100; miscompares = 0; nChecks = 0; cyc = 0;
    seed = $urandom(32'he6c3);
    // The synchronisers reset with the rest, so two edges are enough.
    wt(2);
    reset_n = 1'b1;
    // Commutation table, both directions, then random codes.
    for (int i = 0; i < 48; i++) begin
      h = (i < 32) ? i % 8 : $urandom % 8;
      d = (i < 32) ? i / 16 : $urandom % 2;
      p = (i < 32) ? (i / 8) % 2 : $urandom % 2;
      hallIn = 3'(h); directionInput = d[0]; pwmMode = p ? 2'h1 : 2'h0;
      wt(5);
      e = expOut(h, d, p);
      chk(upperOn, e[5:3], "upper");
      chk(lowerOn, e[2:0], "lower");
      chk({2'h0, hallBiasOutput}, 3'h1, "bias run");
    end
    // Zero duty.
    hallIn = 3'h2; pwmMode = 2'h0;
    wt(ZEROC + 20);
    chk({2'h0, zeroDuty}, 3'h1, "zero");
    chk({2'h0, hallBiasOutput}, 3'h0, "bias zero");
    pwmMode = 2'h1;
    wt(5);
    chk({2'h0, zeroDuty}, 3'h0, "zero end");
    // Lock, then release by direction toggle, stop and zero duty.
    for (int r = 0; r < 3; r++) begin
      onCyc = 16'(100 + $urandom % 400); pwmMode = 2'h2; hallIn = 3'h1;
      wt(LOCKC - 50);
      chk({2'h0, lockActive}, 3'h0, "early lock");
      wt(100);
      chk({2'h0, lockActive}, 3'h1, "lock");
      for (int k = 0; k < 700; k++) begin
        wt(1);
        chk(upperOn, 3'h0, "upper locked");
      end
      if (r == 0) directionInput = ~directionInput;
      if (r == 1) runInput = 1'b0;
      if (r == 2) pwmMode = 2'h0;
      wt(r == 2 ? ZEROC + 20 : 5);
      chk({2'h0, lockActive}, 3'h0, "release");
      runInput = 1'b1;
      hallIn = 3'h3;
    end
    // Thermal shutdown freezes the count. Steady drive clears zero duty
    // at a known edge, so the lock count starts at a known cycle.
    pwmMode = 2'h1;
    wt(1500);
    thermalShutdown = 1'b1;
    wt(3500);
    thermalShutdown = 1'b0;
    wt(1400);
    chk({2'h0, lockActive}, 3'h0, "frozen");
    wt(200);
    chk({2'h0, lockActive}, 3'h1, "resumed");
    lowSupply = 1'b1;
    wt(5);
    chk(upperOn | lowerOn, 3'h0, "low supply");
    lowSupply = 1'b0;
    wt(5);
    chk({2'h0, lockActive}, 3'h0, "low supply lock");
    // Stop: brake, bias off, pump idle; grounded timer pin.
    runInput = 1'b0;
    wt(3);
    for (int k = 0; k < 450; k++) begin
      wt(1);
      chk(upperOn, 3'h0, "stop upper");
      chk({2'h0, pumpClock}, 3'h0, "stop pump");
    end
    chk(lowerOn, 3'h7, "brake");
    chk({2'h0, hallBiasOutput}, 3'h0, "bias stop");
    lockTimerCapGrounded = 1'b1;
    wt(5);
    chk(lowerOn | upperOn, 3'h0, "cap reset");
    lockTimerCapGrounded = 1'b0; runInput = 1'b1; hallIn = 3'h5;
    // Pump half period of 200 cycles.
    n = 0;
    while (pumpClock !== 1'b1 && n < 450) begin wt(1); n++; end
    n = 0;
    while (pumpClock === 1'b1 && n < 450) begin wt(1); n++; end
    chk(3'(n == 200), 3'h1, "pump half period");
    // Current limit with blanking and 50 kHz restart.
    pwmMode = 2'h1; hallIn = 3'h4; directionInput = 1'b0;
    wt(50);
    currentAtLimit = 1'b1;
    n = 0;
    while (upperOn !== 3'h0 && n < 40) begin wt(1); n++; end
    chk(upperOn, 3'h0, "limit cut");
    n = 0;
    while (upperOn === 3'h0 && n < 820) begin wt(1); n++; end
    chk(upperOn, 3'h4, "chop restart");
    n = 0;
    while (upperOn !== 3'h0 && n < 60) begin wt(1); n++; end
    chk(3'(n >= 25 && n <= 32), 3'h1, "blanking");
    currentAtLimit = 1'b0;
    wt(850);
    chk(upperOn, 3'h4, "limit end");
    close_out();
  end
endmodule : testbench
